// ### upf_top.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module upf_top #(
    parameter int DRAIN_CYCLES = upf_pkg::SHUTDOWN_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Register bus.
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    // USB link events from the serial engine.
    input wire logic bus_activity,
    input wire logic sof_valid,
    input wire logic [upf_pkg::FRAME_BITS-1:0] sof_frame,
    input wire logic notify_pending,
    // Power and clock controls.
    output logic usb_clk_enable,
    output logic xcvr_low_power,
    output logic pins_usb_owned,
    output logic analog_enable,
    output logic outputs_enable,
    output logic sleep_block,
    // Interrupt.
    output logic irq
);
    import upf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Control and status state.

    upf_bus_s req;
    logic power_enable;
    logic suspend;
    logic sleep_guard;
    logic busy_soft;
    logic busy_hw;
    logic act_pending;
    logic [FRAME_BITS-1:0] frame;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] events;
    logic [31:0] next_rdata;

    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // Returns true when a write hits the given offset.
    function automatic logic wr_hit(input upf_bus_s r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Shutdown sequencer that produces the hardware busy indication.
    upf_shutdown #(
        .DRAIN_CYCLES(DRAIN_CYCLES)
    ) u_shutdown (
        .clk(clk),
        .resetn(resetn),
        .enable(power_enable),
        .busy(busy_hw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power control register; writable bits reset to zero.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            power_enable <= RESET_POWER_CONTROL[BIT_POWER_ENABLE];
            suspend <= RESET_POWER_CONTROL[BIT_SUSPEND];
            sleep_guard <= RESET_POWER_CONTROL[BIT_SLEEP_GUARD];
            busy_soft <= RESET_POWER_CONTROL[BIT_BUSY];
        end else if (wr_hit(req, ADDR_POWER_CONTROL)) begin
            power_enable <= req.wdata[BIT_POWER_ENABLE];
            suspend <= req.wdata[BIT_SUSPEND];
            sleep_guard <= req.wdata[BIT_SLEEP_GUARD];
            busy_soft <= req.wdata[BIT_BUSY];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Activity pending: set on activity, cleared when the interrupt is raised.
    // The pending state lasts one cycle after the last activity: the status bit is raised on the next edge.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_pending <= 1'b0;
        end else if (bus_activity && power_enable) begin
            act_pending <= 1'b1;
        end else if (act_pending) begin
            act_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame number capture on each start-of-frame token received while powered and not suspended.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame <= RESET_FRAME;
        end else if (sof_valid && power_enable && !suspend) begin
            frame <= sof_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status (write one to clear, set wins) and mask.

    assign events[BIT_IRQ_ACTIVITY] = act_pending;
    assign events[BIT_IRQ_SOF] = sof_valid && power_enable && !suspend;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= RESET_IRQ;
        end else begin
            for (int i = 0; i < IRQ_BITS; i++) begin
                if (events[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_hit(req, ADDR_IRQ_STATUS) && req.wdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= RESET_IRQ;
        end else if (wr_hit(req, ADDR_IRQ_MASK)) begin
            irq_mask <= req.wdata[IRQ_BITS-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Power outputs.

    // The USB clock runs only when powered and not suspended.
    assign usb_clk_enable = power_enable && !suspend;
    assign xcvr_low_power = !power_enable || suspend;
    // Disabled module releases pins, holds outputs, shuts analog.
    assign pins_usb_owned = power_enable;
    assign analog_enable = power_enable;
    assign outputs_enable = power_enable && !suspend;
    // Sleep is blocked only while the guard is set.
    assign sleep_block = sleep_guard && (bus_activity || act_pending || notify_pending);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped offsets read zero.

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (req.addr)
            ADDR_POWER_CONTROL: begin
                next_rdata[BIT_POWER_ENABLE] = power_enable;
                next_rdata[BIT_SUSPEND] = suspend;
                next_rdata[BIT_BUSY] = busy_hw || busy_soft;
                next_rdata[BIT_SLEEP_GUARD] = sleep_guard;
                next_rdata[BIT_ACT_PENDING] = act_pending;
            end
            ADDR_FRAME_LOW: begin
                next_rdata[FRAME_LOW_BITS-1:0] = frame[FRAME_LOW_BITS-1:0];
            end
            ADDR_FRAME_HIGH: begin
                next_rdata[FRAME_HIGH_BITS-1:0] = frame[FRAME_BITS-1:FRAME_LOW_BITS];
            end
            ADDR_IRQ_STATUS: begin
                next_rdata[IRQ_BITS-1:0] = irq_status;
            end
            ADDR_IRQ_MASK: begin
                next_rdata[IRQ_BITS-1:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_PEND_SET: assert property (@(posedge clk) disable iff (!resetn)
        (bus_activity && power_enable) |=> act_pending)
        else $error("Pending flag not set after activity.");

    AST_PEND_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        (act_pending && !(bus_activity && power_enable)) |=> (!act_pending && irq_status[0]))
        else $error("Pending flag not cleared on interrupt.");

    AST_SLEEP_GUARD: assert property (@(posedge clk) disable iff (!resetn)
        !sleep_guard |-> !sleep_block)
        else $error("Sleep blocked without guard.");

    AST_SLEEP_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
        (sleep_guard && notify_pending) |-> sleep_block)
        else $error("Sleep not blocked with pending notification.");

    AST_BUSY_ON: assert property (@(posedge clk) disable iff (!resetn)
        (power_enable && $past(power_enable)) |-> busy_hw)
        else $error("Module not busy while on.");

    AST_BUSY_DRAIN: assert property (@(posedge clk) disable iff (!resetn)
        $fell(power_enable) |-> busy_hw)
        else $error("Busy dropped at turn-off.");

    AST_SUSPEND: assert property (@(posedge clk) disable iff (!resetn)
        suspend |-> (!usb_clk_enable && xcvr_low_power))
        else $error("Clock running in suspend.");

    AST_POWER_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !power_enable |-> (!pins_usb_owned && !analog_enable && !outputs_enable))
        else $error("Outputs active while disabled.");

    AST_FRAME_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
        (sof_valid && usb_clk_enable) |=> (frame == $past(sof_frame)))
        else $error("Frame number not captured.");

    AST_FRAME_HIGH_READ: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_FRAME_HIGH) |=> (bus_rdata[31:3] == 29'h0))
        else $error("Frame high upper bits not zero.");

    AST_PEND_RO: assert property (@(posedge clk) disable iff (!resetn)
        (bus_wr && bus_addr == ADDR_POWER_CONTROL && !act_pending && !bus_activity)
        |=> !act_pending)
        else $error("Pending flag written by software.");

    AST_PEND_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        (!act_pending && !(bus_activity && power_enable)) |=> !act_pending)
        else $error("Pending flag set without activity.");

    AST_PEND_READ: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_POWER_CONTROL)
        |=> (bus_rdata[BIT_ACT_PENDING] == $past(act_pending)))
        else $error("Pending flag read back wrong.");

    AST_SLEEP_ACTIVITY: assert property (@(posedge clk) disable iff (!resetn)
        (sleep_guard && bus_activity) |-> sleep_block)
        else $error("Sleep not blocked during bus activity.");

    ////////////////////////////////////////////////////////////////////////////
    // Register read and write checks, with output, frame hold and token status checks.

    AST_BUSY_READ: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_POWER_CONTROL && busy_hw) |=> bus_rdata[BIT_BUSY])
        else $error("Busy bit reads zero while busy.");

    AST_READY_READ: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_POWER_CONTROL && !busy_hw && !busy_soft && !power_enable)
        |=> !bus_rdata[BIT_BUSY])
        else $error("Busy bit reads one while ready.");

    AST_RESUME: assert property (@(posedge clk) disable iff (!resetn)
        (power_enable && !suspend) |-> (usb_clk_enable && !xcvr_low_power))
        else $error("Clock gated outside suspend.");

    AST_POWER_ON: assert property (@(posedge clk) disable iff (!resetn)
        power_enable |-> (pins_usb_owned && analog_enable))
        else $error("Pins or analog released while enabled.");

    AST_FRAME_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !(sof_valid && usb_clk_enable) |=> $stable(frame))
        else $error("Frame number changed without a token.");

    AST_FRAME_LOW_READ: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_FRAME_LOW)
        |=> (bus_rdata == {24'h00_0000, $past(frame[7:0])}))
        else $error("Frame low read back wrong.");

    AST_FRAME_HIGH_VALUE: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_FRAME_HIGH) |=> (bus_rdata[2:0] == $past(frame[10:8])))
        else $error("Frame high read back wrong.");

    AST_CTRL_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
        (bus_rd && bus_addr == ADDR_POWER_CONTROL)
        |=> (bus_rdata[31:8] == 24'h00_0000 && bus_rdata[6:5] == 2'h0 && !bus_rdata[2]))
        else $error("Unused control bits not zero.");

    AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        (bus_wr && bus_addr == ADDR_POWER_CONTROL)
        |=> (power_enable == $past(bus_wdata[BIT_POWER_ENABLE])
            && suspend == $past(bus_wdata[BIT_SUSPEND])
            && sleep_guard == $past(bus_wdata[BIT_SLEEP_GUARD])))
        else $error("Control write did not land.");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        !bus_rd |=> (bus_rdata == 32'h0000_0000))
        else $error("Read data not zero outside a read.");

    AST_SOF_IRQ: assert property (@(posedge clk) disable iff (!resetn)
        (sof_valid && usb_clk_enable) |=> irq_status[BIT_IRQ_SOF])
        else $error("Token did not raise its status bit.");

endmodule

// ### upf_pkg.sv
package upf_pkg;

    // Register word offsets (byte addresses, one aligned word each).
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FRAME_LOW = 8'h04;
    localparam logic [7:0] ADDR_FRAME_HIGH = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // Power control field positions.
    localparam int BIT_POWER_ENABLE = 0;
    localparam int BIT_SUSPEND = 1;
    localparam int BIT_BUSY = 3;
    localparam int BIT_SLEEP_GUARD = 4;
    localparam int BIT_ACT_PENDING = 7;

    // Interrupt status and mask field positions.
    localparam int BIT_IRQ_ACTIVITY = 0;
    localparam int BIT_IRQ_SOF = 1;
    localparam int IRQ_BITS = 2;

    // Frame number layout.
    localparam int FRAME_BITS = 11;
    localparam int FRAME_LOW_BITS = 8;
    localparam int FRAME_HIGH_BITS = 3;

    // Values after reset.
    localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
    localparam logic [10:0] RESET_FRAME = 11'h000;
    localparam logic [1:0] RESET_IRQ = 2'h0;

    // Time the module stays busy after power-enable is cleared.
    localparam int SHUTDOWN_NS = 400;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SHUTDOWN_CYCLES = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Shutdown sequencer states, one bit changing per step except drain back to off.
    typedef enum logic [1:0] {
        UPF_OFF = 2'b00,
        UPF_ON = 2'b01,
        UPF_DRAIN = 2'b11
    } upf_state_e;

    // Register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } upf_bus_s;

endpackage

// ### upf_shutdown.sv
`timescale 1ns/100ps
// Keeps the module busy while it is on and for a drain time after it is turned off.
module upf_shutdown #(
    parameter int DRAIN_CYCLES = upf_pkg::SHUTDOWN_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Control and status.
    input wire logic enable,
    output logic busy
);
    import upf_pkg::*;

    // Refuses drain times that the 8-bit down-counter cannot hold.
    if (DRAIN_CYCLES < 1 || DRAIN_CYCLES > 255) begin : g_bad_drain
        $error("DRAIN_CYCLES out of range");
    end

    upf_state_e state;
    logic [7:0] count;

    // Sequencer: off, on, and draining back to off.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= UPF_OFF;
            count <= 8'h00;
        end else begin
            unique case (state)
                UPF_OFF: begin
                    if (enable) begin
                        state <= UPF_ON;
                    end
                end
                UPF_ON: begin
                    if (!enable) begin
                        state <= UPF_DRAIN;
                        count <= 8'(DRAIN_CYCLES - 1);
                    end
                end
                UPF_DRAIN: begin
                    // A premature re-enable goes back on once the count reaches zero, so busy never dips.
                    if (count == 8'h00) begin
                        state <= enable ? UPF_ON : UPF_OFF;
                    end else begin
                        count <= count - 8'h01;
                    end
                end
                default: begin
                    state <= UPF_OFF;
                end
            endcase
        end
    end

    // Busy while active or still draining.
    assign busy = (state != UPF_OFF);

endmodule

// ### upf_link_model.sv
`timescale 1ns/100ps
// Stands in for the serial engine that faces the USB host: tokens, activity, notifications.
module upf_link_model (
    // Clock.
    input wire logic clk,
    // Link events.
    output logic bus_activity,
    output logic sof_valid,
    output logic [upf_pkg::FRAME_BITS-1:0] sof_frame,
    output logic notify_pending
);
    import upf_pkg::*;

    // Outside a token the frame lines show the inverse of the last value, or 11'h555 before the first token, never a held copy.
    initial begin
        bus_activity = 1'b0;
        sof_valid = 1'b0;
        sof_frame = 11'h555;
        notify_pending = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sends one start-of-frame token, one cycle long.
    task automatic send_sof(input logic [10:0] f);
        @(posedge clk);
        sof_valid <= 1'b1;
        sof_frame <= f;
        @(posedge clk);
        sof_valid <= 1'b0;
        sof_frame <= ~f;
    endtask

    // One cycle of detected bus activity.
    task automatic pulse_activity();
        @(posedge clk);
        bus_activity <= 1'b1;
        @(posedge clk);
        bus_activity <= 1'b0;
    endtask

    // Raises or drops a pending notification; returns once it has landed.
    task automatic set_notify(input logic v);
        @(posedge clk);
        notify_pending <= v;
        #1;
    endtask
endmodule

// ### upf_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the power control and frame number block.
module testbench;
    import upf_pkg::*;
    localparam int DRAIN = 4;
    logic clk, resetn, bus_wr, bus_rd;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, rv, m_ctrl, m_stat;
    logic bus_activity, sof_valid, notify_pending;
    logic [FRAME_BITS-1:0] sof_frame, f;
    logic usb_clk_enable, xcvr_low_power, pins_usb_owned, analog_enable;
    logic outputs_enable, sleep_block, irq;
    wire [4:0] dout = {usb_clk_enable, xcvr_low_power, pins_usb_owned, analog_enable,
        outputs_enable};
    int bad_count, total_checks, i, n, cyc, t_off;

    upf_top #(.DRAIN_CYCLES(DRAIN)) dut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_activity(bus_activity), .sof_valid(sof_valid), .sof_frame(sof_frame),
        .notify_pending(notify_pending), .usb_clk_enable(usb_clk_enable),
        .xcvr_low_power(xcvr_low_power), .pins_usb_owned(pins_usb_owned),
        .analog_enable(analog_enable), .outputs_enable(outputs_enable),
        .sleep_block(sleep_block), .irq(irq));
    upf_link_model link (.clk(clk), .bus_activity(bus_activity), .sof_valid(sof_valid),
        .sof_frame(sof_frame), .notify_pending(notify_pending));

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    // Counts rising edges so that timed expectations can be worked out.
    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One write cycle; returns once the write has landed.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    // One read cycle; data are taken in the cycle after the strobe.
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 rv = bus_rdata;
        chk(what, exp, rv);
    endtask

    // Expected control word from the model, with hardware busy and pending bits.
    function automatic logic [31:0] ectrl(input logic b, input logic p);
        return m_ctrl | {24'h0, p, 3'h0, b, 3'h0};
    endfunction

    // Expected power and clock outputs from the model.
    function automatic logic [4:0] outs();
        return {m_ctrl[0] & ~m_ctrl[1], ~m_ctrl[0] | m_ctrl[1], m_ctrl[0], m_ctrl[0],
            m_ctrl[0] & ~m_ctrl[1]};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        m_ctrl = 32'h0;
        m_stat = 32'h0;
        bad_count = 0;
        total_checks = 0;
        void'($urandom(32'hf202));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        #1 chk("outputs", outs(), dout);
        rchk("control", ADDR_POWER_CONTROL, 32'h0);
        rchk("frame low", ADDR_FRAME_LOW, 32'h0);
        rchk("frame high", ADDR_FRAME_HIGH, 32'h0);
        rchk("unmapped", 8'h14, 32'h0);
        $display("test reset done");
        // Power on with the guard; the pending bit ignores the write.
        m_ctrl = 32'h11;
        wr(ADDR_POWER_CONTROL, 32'h91);
        chk("outputs", outs(), dout);
        rchk("control", ADDR_POWER_CONTROL, ectrl(1'b1, 1'b0));
        link.set_notify(1'b1);
        chk("sleep block", 32'h1, sleep_block);
        wr(ADDR_POWER_CONTROL, 32'h01);
        chk("sleep block", 32'h0, sleep_block);
        wr(ADDR_POWER_CONTROL, m_ctrl);
        link.set_notify(1'b0);
        // Suspend gates the clock and ignores tokens.
        m_ctrl = 32'h13;
        wr(ADDR_POWER_CONTROL, m_ctrl);
        chk("outputs", outs(), dout);
        link.send_sof(11'h2aa);
        rchk("frame low", ADDR_FRAME_LOW, 32'h0);
        m_ctrl = 32'h11;
        wr(ADDR_POWER_CONTROL, m_ctrl);
        chk("outputs", outs(), dout);
        $display("test power done");
        // Frame capture across boundary and random numbers, with a masked interrupt.
        wr(ADDR_IRQ_MASK, 32'h2);
        for (i = 0; i < 10; i++) begin
            f = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($urandom());
            link.send_sof(f);
            m_stat = 32'h2;
            rchk("frame low", ADDR_FRAME_LOW, {24'h0, f[7:0]});
            rchk("frame high", ADDR_FRAME_HIGH, {29'h0, f[10:8]});
            chk("irq", 32'h1, irq);
        end
        rchk("status", ADDR_IRQ_STATUS, m_stat);
        wr(ADDR_IRQ_STATUS, 32'h2);
        chk("irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h0);
        link.send_sof(11'h123);
        rchk("status", ADDR_IRQ_STATUS, m_stat);
        chk("irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h2);
        chk("irq", 32'h1, irq);
        wr(ADDR_IRQ_STATUS, 32'h2);
        chk("irq", 32'h0, irq);
        $display("test frame done");
        // Activity sets pending, then the interrupt takes over and pending clears.
        wr(ADDR_IRQ_MASK, 32'h1);
        fork
            link.pulse_activity();
            begin
                @(posedge clk);
                rchk("pending", ADDR_POWER_CONTROL, ectrl(1'b1, 1'b1));
            end
        join
        rchk("pending", ADDR_POWER_CONTROL, ectrl(1'b1, 1'b0));
        rchk("status", ADDR_IRQ_STATUS, 32'h1);
        chk("irq", 32'h1, irq);
        wr(ADDR_IRQ_STATUS, 32'h1);
        chk("irq", 32'h0, irq);
        $display("test activity done");
        // Power off: busy drains before any further register write.
        m_ctrl = 32'h0;
        wr(ADDR_POWER_CONTROL, m_ctrl);
        t_off = cyc;
        chk("outputs", outs(), dout);
        rchk("control", ADDR_POWER_CONTROL, ectrl(1'b1, 1'b0));
        n = 0;
        // Busy holds through the edge that sees enable low plus the drain time;
        // each poll samples two edges after the call.
        while (rv[BIT_BUSY] !== 1'b0 && n < 20) begin
            n++;
            rchk("poll", ADDR_POWER_CONTROL, ectrl((cyc + 2 - t_off) <= DRAIN + 1, 1'b0));
        end
        if (n == 20) begin
            bad_count++;
            results();
        end
        chk("control", ectrl(1'b0, 1'b0), rv);
        wr(ADDR_POWER_CONTROL, 32'h1);
        m_ctrl = 32'h1;
        chk("outputs", outs(), dout);
        $display("test shutdown done");
        results();
    end
endmodule
